// ===== aid_map.vh
// Register map, field layout and timing constants of the analog input core
`ifndef AID_MAP_VH
`define AID_MAP_VH
`define AID_CTRL_OFS    8'h00
`define AID_CHCFG_OFS   8'h04
`define AID_FIXREF_OFS  8'h14
`define AID_DIAG_OFS    8'h18
`define AID_LIMEVT_OFS  8'h1C
`define AID_LIM_OFS     8'h20
`define AID_VAL_OFS     8'h30
`define AID_CTRL_GRP    0
`define AID_CTRL_LIMEN  1
`define AID_CTRL_F60    2
`define AID_CTRL_FAST   3
`define AID_CFG_WB      5
`define AID_CFG_OVF     6
`define AID_CFG_SHIN    7
`define AID_CFG_SHOUT   8
`define AID_TY_OFF      3'h0
`define AID_TY_U10      3'h1
`define AID_TY_U15      3'h2
`define AID_TY_I420     3'h3
`define AID_TY_TC       3'h4
`define AID_TY_TC80     3'h5
`define AID_CP_NONE     2'h0
`define AID_CP_INT      2'h1
`define AID_CP_FIX      2'h2
`define AID_CTRL_RST    4'h1
`define AID_CFG_RST     11'h000
`define AID_FIXREF_RST  16'h0000
`define AID_LIM_RST     32'h7FFF8000
`define AID_CODE_WB     16'h7FFF
`define AID_CODE_LOW    16'h8000
`define AID_FIXREF_MIN  (-1450)
`define AID_FIXREF_MAX  1550
`define AID_U_LO_MV     1000
`define AID_U_HI_MV     5000
`define AID_U_WB_MV     296
`define AID_I_LO_UA     4000
`define AID_I_HI_UA     20000
`define AID_I_WB_UA     1185
`define AID_CLK_MHZ     10
`define AID_T50_US      20000
`define AID_T60_US      16667
`define AID_TFAST_US    2500
`endif

// ===== aid_core.v
// Analog input post-conversion core: scheduling, smoothing, diagnostics, limits
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "aid_map.vh"
// Function
// RULE1 - Encoder supply short only with group diagnostics
// RULE2 - Channel short independent of group, range dependent
// RULE3 - Group diagnostics switches all diagnostics off except channel short
// RULE4 - Limit event when value rises above high
// RULE5 - Limit event when value drops below low
// RULE6 - Integration time follows interference frequency setting
// RULE7 - Fast mode short conversion, slow suppresses interference
// RULE8 - Disabled channel takes no conversion time
// RULE9 - Average samples over four smoothing levels
// RULE10 - Level sets cycles to reach 63 percent
// RULE11 - Encoder supply short raises diagnostics event
// RULE12 - Report input signal line shorts when enabled
// RULE13 - Report output line shorts when enabled
// RULE14 - Report wire break when enabled
// RULE15 - Wire break with diagnostics gives 7FFF
// RULE16 - Wire break without gives 8000, underflow alarm
// RULE17 - Open circuit below 0.296 V or 1.185 mA
// RULE18 - Overflow and underflow diagnostics when enabled
// RULE19 - Thermocouple value adds reference junction temperature (code adds it for type TC only, not for TC80)
// RULE20 - No compensation assumes zero degrees
// RULE21 - Internal sensor shared by internal-compensated channels
// RULE22 - Fixed reference only with fixed mode, ranged
// RULE23 - No wire break check on 80 mV
// RULE24 - Smoothing depths configurable, increasing weak to strong
// RULE25 - One limit event per crossing
module aid_core #(
    parameter        SH_WEAK  = 2,
    parameter        SH_MED   = 3,
    parameter        SH_STR   = 5,
    parameter [19:0] CYC_50   = `AID_T50_US * `AID_CLK_MHZ,
    parameter [19:0] CYC_60   = `AID_T60_US * `AID_CLK_MHZ,
    parameter [19:0] CYC_FAST = `AID_TFAST_US * `AID_CLK_MHZ,
    parameter        FS_CODE  = 27648,
    parameter [15:0] OVF_CODE = 16'h7EFF,
    parameter [15:0] UDF_CODE = 16'hED00
) (
    // Clock, reset, enable
    input  wire        REF_CLK_I,
    input  wire        RST_B_I,
    input  wire        CE_I,
    // APB slave
    input  wire        PSEL_I,
    input  wire        PENABLE_I,
    input  wire        PWRITE_I,
    input  wire [7:0]  PADDR_I,
    input  wire [31:0] PWDATA_I,
    output reg  [31:0] PRDATA_O,
    output reg         PREADY_O,
    output reg         PSLVERR_O,
    // Converter side
    output reg         CONV_GATE_O,
    output reg  [1:0]  CONV_CH_O,
    output reg         CONV_REQ_O,
    input  wire        SMP_VALID_I,
    input  wire [15:0] SMP_DATA_I,
    input  wire        SMP_OPEN_I,
    input  wire        SMP_SHORT_I,
    input  wire        SMP_OSHORT_I,
    // Sensors and pins
    input  wire [15:0] TEMP_INT_I,
    input  wire        ENC_SHORT_I,
    // Alarms to the master
    output reg         PROC_IRQ_O,
    output reg         DIAG_EVT_O,
    output reg         DIAG_ENC_O
);
    localparam NCH = 4;
    localparam S_SEL  = 2'h0;
    localparam S_INT  = 2'h1;
    localparam S_WAIT = 2'h2;
    // Open circuit thresholds as converter codes of the rated span
    localparam integer WBU_I = (`AID_U_WB_MV - `AID_U_LO_MV) * FS_CODE
                               / (`AID_U_HI_MV - `AID_U_LO_MV);
    localparam integer WBI_I = (`AID_I_WB_UA - `AID_I_LO_UA) * FS_CODE
                               / (`AID_I_HI_UA - `AID_I_LO_UA);
    localparam signed [15:0] WBU = WBU_I[15:0];
    localparam signed [15:0] WBI = WBI_I[15:0];

    reg  [3:0]  ctrl_q;
    reg  [10:0] cfg_q [0:NCH-1];
    reg  [31:0] lim_q [0:NCH-1];
    reg  [15:0] fixref_q;
    reg  [1:0]  st_q;
    reg  [1:0]  cur_q;
    reg  [19:0] cnt_q;
    reg         s1_q;
    reg         s2_q;
    reg         s3_q;
    reg         enc_q;
    reg  [31:0] rd_d;
    reg         map_d;
    wire [15:0]       val_w  [0:NCH-1];
    wire [4:0]        diag_w [0:NCH-1];
    wire [NCH-1:0]    hi_rise;
    wire [NCH-1:0]    lo_rise;
    wire [NCH-1:0]    d_rise;
    wire [NCH-1:0]    evt_hi;
    wire [NCH-1:0]    evt_lo;
    wire [NCH-1:0]    fix_sel;
    wire              grp    = ctrl_q[`AID_CTRL_GRP];
    wire              lim_en = ctrl_q[`AID_CTRL_LIMEN];
    wire              setup  = PSEL_I & ~PENABLE_I;
    wire              wr_acc = PSEL_I & PENABLE_I & PWRITE_I & PREADY_O;
    wire [7:0]        adr    = PADDR_I;
    wire [1:0]        cfg_ix = adr[3:2] - 2'h1;
    wire [1:0]        adr_ix = adr[3:2];
    wire              smp_take = (st_q == S_WAIT) & SMP_VALID_I;
    wire [7:0]        lim_clr = (wr_acc && adr == `AID_LIMEVT_OFS) ? PWDATA_I[7:0] : 8'h00;
    wire signed [15:0] fix_in = PWDATA_I[15:0];
    wire              fix_ok = (fix_in >= `AID_FIXREF_MIN) && (fix_in <= `AID_FIXREF_MAX);
    wire [2:0]        cur_ty = cfg_q[cur_q][2:0];
    wire              cur_ui = (cur_ty != `AID_TY_TC) && (cur_ty != `AID_TY_TC80);
    wire              enc_d  = grp & enc_q;

    // Address decode and read mux
    always @* begin
        rd_d  = 32'h0000_0000;
        map_d = (adr[1:0] == 2'h0);
        if (adr == `AID_CTRL_OFS) begin
            rd_d[3:0] = ctrl_q;
        end else if (adr >= `AID_CHCFG_OFS && adr < `AID_FIXREF_OFS) begin
            rd_d[10:0] = cfg_q[cfg_ix];
        end else if (adr == `AID_FIXREF_OFS) begin
            rd_d[15:0] = fixref_q;
        end else if (adr == `AID_DIAG_OFS) begin
            rd_d = {enc_d, 2'h0, diag_w[3], 3'h0, diag_w[2], 3'h0,
                    diag_w[1], 3'h0, diag_w[0]};
        end else if (adr == `AID_LIMEVT_OFS) begin
            rd_d[7:0] = {evt_lo, evt_hi};
        end else if (adr >= `AID_LIM_OFS && adr < `AID_VAL_OFS) begin
            rd_d = lim_q[adr_ix];
        end else if (adr >= `AID_VAL_OFS && adr < 8'h40) begin
            rd_d[15:0] = val_w[adr_ix];
        end else begin
            map_d = 1'b0;
        end
    end

    // Zero-wait APB answer, write lands at the access edge
    integer i;
    always @(posedge REF_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            PREADY_O  <= 1'b0;
            PRDATA_O  <= 32'h0000_0000;
            PSLVERR_O <= 1'b0;
            ctrl_q    <= `AID_CTRL_RST;
            fixref_q  <= `AID_FIXREF_RST;
            for (i = 0; i < NCH; i = i + 1) begin
                cfg_q[i] <= `AID_CFG_RST;
                lim_q[i] <= `AID_LIM_RST;
            end
        end else if (CE_I) begin
            PREADY_O  <= setup;
            PRDATA_O  <= (setup & ~PWRITE_I & map_d) ? rd_d : 32'h0000_0000;
            PSLVERR_O <= setup & ~map_d;
            if (wr_acc && adr == `AID_CTRL_OFS) begin
                ctrl_q <= PWDATA_I[3:0];
            end else if (wr_acc && adr >= `AID_CHCFG_OFS && adr < `AID_FIXREF_OFS) begin
                cfg_q[cfg_ix] <= PWDATA_I[10:0];
            end else if (wr_acc && adr == `AID_FIXREF_OFS) begin
                if ((|fix_sel) && fix_ok) begin
                    fixref_q <= PWDATA_I[15:0]; // [RULE22]
                end
            end else if (wr_acc && adr >= `AID_LIM_OFS && adr < `AID_VAL_OFS) begin
                lim_q[adr_ix] <= PWDATA_I;
            end
        end
    end

    // Channel scheduler; skipping costs one clock only
    always @(posedge REF_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            st_q        <= S_SEL;
            cur_q       <= 2'h0;
            cnt_q       <= 20'h00000;
            CONV_GATE_O <= 1'b0;
            CONV_CH_O   <= 2'h0;
            CONV_REQ_O  <= 1'b0;
        end else if (CE_I) begin
            CONV_REQ_O <= 1'b0;
            case (st_q)
                S_SEL: begin
                    if (cur_ty == `AID_TY_OFF) begin
                        cur_q <= cur_q + 2'h1; // [RULE8]
                    end else begin
                        CONV_CH_O   <= cur_q;
                        CONV_GATE_O <= 1'b1;
                        st_q        <= S_INT;
                        if (ctrl_q[`AID_CTRL_FAST] && cur_ui) begin
                            cnt_q <= CYC_FAST; // [RULE7]
                        end else if (ctrl_q[`AID_CTRL_F60]) begin
                            cnt_q <= CYC_60; // [RULE6]
                        end else begin
                            cnt_q <= CYC_50; // [RULE6]
                        end
                    end
                end
                S_INT: begin
                    if (cnt_q <= 20'h00001) begin
                        CONV_GATE_O <= 1'b0;
                        CONV_REQ_O  <= 1'b1;
                        st_q        <= S_WAIT;
                    end else begin
                        cnt_q <= cnt_q - 20'h00001;
                    end
                end
                S_WAIT: begin
                    if (SMP_VALID_I) begin
                        cur_q <= cur_q + 2'h1;
                        st_q  <= S_SEL;
                    end
                end
                default: begin
                    st_q <= S_SEL;
                end
            endcase
        end
    end

    // Per-channel processing
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_ch
            reg  [15:0] y_q;
            reg  [15:0] val_q;
            reg  [4:0]  diag_q;
            reg         above_q;
            reg         below_q;
            reg         ehi_q;
            reg         elo_q;
            reg         hir_q;
            reg         lor_q;
            reg         dr_q;
            wire [10:0] cfg   = cfg_q[g];
            wire [2:0]  ty    = cfg[2:0];
            wire [1:0]  lvl   = cfg[4:3];
            wire [1:0]  comp  = cfg[10:9];
            wire        wben  = cfg[`AID_CFG_WB];
            wire        ovfen = cfg[`AID_CFG_OVF];
            wire        hit   = smp_take && (cur_q == g);
            wire        is_tc = (ty == `AID_TY_TC) || (ty == `AID_TY_TC80);
            wire        is_rt = (ty == `AID_TY_U15) || (ty == `AID_TY_I420);
            wire signed [15:0] raw = SMP_DATA_I;
            wire signed [15:0] hi  = lim_q[g][31:16];
            wire signed [15:0] lo  = lim_q[g][15:0];
            // Threshold sits at the undershoot boundary of the live-zero ranges
            wire wb_rt = ((ty == `AID_TY_U15) && (raw < WBU)) ||
                         ((ty == `AID_TY_I420) && (raw < WBI)); // [RULE17]
            wire wb = wb_rt | ((ty == `AID_TY_TC) & SMP_OPEN_I); // [RULE23]
            wire signed [15:0] refv = (comp == `AID_CP_INT) ? TEMP_INT_I :
                                      (comp == `AID_CP_FIX) ? fixref_q :
                                      16'h0000; // [RULE20] [RULE21]
            wire [16:0] sum = {raw[15], raw} + {refv[15], refv}; // [RULE19]
            wire [15:0] sat = (sum[16] != sum[15]) ?
                              (sum[16] ? 16'h8000 : 16'h7FFF) : sum[15:0];
            wire [15:0] x   = (ty == `AID_TY_TC) ? sat : raw;
            wire signed [16:0] dif = {x[15], x} - {y_q[15], y_q};
            // First-order filter: 63 percent after 2^shift module cycles
            wire signed [16:0] stp = (lvl == 2'h1) ? (dif >>> SH_WEAK) :
                                     (lvl == 2'h2) ? (dif >>> SH_MED) :
                                     (dif >>> SH_STR); // [RULE9] [RULE10] [RULE24]
            wire [15:0] y_d = (lvl == 2'h0) ? x : (y_q + stp[15:0]);
            wire [15:0] out = (wb && wben) ? `AID_CODE_WB :
                              wb ? `AID_CODE_LOW : y_d; // [RULE15] [RULE16]
            wire ovf = raw > $signed(OVF_CODE);
            wire udf = raw < $signed(UDF_CODE);
            wire [4:0] dn;
            assign dn[0] = grp & wben & wb; // [RULE14] [RULE3]
            assign dn[1] = grp & ovfen & ~wb & ovf; // [RULE18]
            assign dn[2] = grp & ovfen & (wb ? ~wben : udf); // [RULE16] [RULE18]
            assign dn[3] = cfg[`AID_CFG_SHIN] & is_rt & SMP_SHORT_I; // [RULE2] [RULE12]
            assign dn[4] = grp & cfg[`AID_CFG_SHOUT] & SMP_OSHORT_I; // [RULE13]
            wire ab_d = $signed(out) > hi;
            wire bl_d = $signed(out) < lo;
            wire hr = hit & lim_en & ab_d & ~above_q; // [RULE4] [RULE25]
            wire lr = hit & lim_en & bl_d & ~below_q; // [RULE5] [RULE25]
            always @(posedge REF_CLK_I or negedge RST_B_I) begin
                if (!RST_B_I) begin
                    y_q     <= 16'h0000;
                    val_q   <= 16'h0000;
                    diag_q  <= 5'h00;
                    above_q <= 1'b0;
                    below_q <= 1'b0;
                    ehi_q   <= 1'b0;
                    elo_q   <= 1'b0;
                    hir_q   <= 1'b0;
                    lor_q   <= 1'b0;
                    dr_q    <= 1'b0;
                end else if (CE_I) begin
                    hir_q <= hr;
                    lor_q <= lr;
                    dr_q  <= hit & (|(dn & ~diag_q));
                    // New crossing beats a same-cycle clear
                    ehi_q <= (ehi_q & ~lim_clr[g]) | hr;
                    elo_q <= (elo_q & ~lim_clr[NCH + g]) | lr;
                    if (ty == `AID_TY_OFF || !grp) begin
                        diag_q <= {1'b0, (ty != `AID_TY_OFF) & diag_q[3], 3'h0};
                    end
                    if (ty == `AID_TY_OFF) begin
                        above_q <= 1'b0;
                        below_q <= 1'b0;
                    end else if (hit) begin
                        y_q     <= y_d;
                        val_q   <= out;
                        diag_q  <= dn;
                        above_q <= ab_d;
                        below_q <= bl_d;
                    end
                end
            end
            assign val_w[g]   = val_q;
            assign diag_w[g]  = diag_q;
            assign hi_rise[g] = hir_q;
            assign lo_rise[g] = lor_q;
            assign d_rise[g]  = dr_q;
            assign evt_hi[g]  = ehi_q;
            assign evt_lo[g]  = elo_q;
            assign fix_sel[g] = is_tc & (comp == `AID_CP_FIX);
        end
    endgenerate

    // Encoder supply short pin: three stages, accept once two agree
    always @(posedge REF_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            s1_q       <= 1'b0;
            s2_q       <= 1'b0;
            s3_q       <= 1'b0;
            enc_q      <= 1'b0;
            DIAG_ENC_O <= 1'b0;
            DIAG_EVT_O <= 1'b0;
            PROC_IRQ_O <= 1'b0;
        end else if (CE_I) begin
            s1_q       <= ENC_SHORT_I;
            s2_q       <= s1_q;
            s3_q       <= s2_q;
            if (s2_q == s3_q) begin
                enc_q <= s3_q;
            end
            DIAG_ENC_O <= enc_d; // [RULE1] [RULE3]
            DIAG_EVT_O <= (|d_rise) | (enc_d & ~DIAG_ENC_O); // [RULE11]
            PROC_IRQ_O <= (|hi_rise) | (|lo_rise); // [RULE4] [RULE5]
        end
    end
endmodule // aid_core
`default_nettype wire

// ===== aid_core_asserts.sv
// Port checks for the analog input core
`timescale 1ns/1ns
`default_nettype none
module aid_chk #(
    parameter [19:0] CYC_50   = 20'h8,
    parameter [19:0] CYC_60   = 20'h6,
    parameter [19:0] CYC_FAST = 20'h4
) (
    // Clock, reset and bus
    input wire        REF_CLK_I,
    input wire        RST_B_I,
    input wire        PSEL_I,
    input wire        PENABLE_I,
    input wire        PWRITE_I,
    input wire [7:0]  PADDR_I,
    input wire [31:0] PWDATA_I,
    input wire        PREADY_O,
    input wire        PSLVERR_O,
    // Converter, pins and alarms
    input wire        CONV_GATE_O,
    input wire [1:0]  CONV_CH_O,
    input wire        CONV_REQ_O,
    input wire        ENC_SHORT_I,
    input wire        PROC_IRQ_O,
    input wire        DIAG_EVT_O,
    input wire        DIAG_ENC_O
);
    reg  [3:0]  ctl_q;
    reg  [3:0]  off_q;
    reg  [3:0]  tc_q;
    reg         dty_q;
    reg  [19:0] cnt_q;
    wire        cfg_w = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I & (PADDR_I < 8'h14)
                        & (PADDR_I[1:0] == 2'h0);
    wire [1:0]  idx_w = PADDR_I[3:2] - 2'h1;
    wire [19:0] exp_w = (ctl_q[3] & ~tc_q[CONV_CH_O]) ? CYC_FAST : ctl_q[2] ? CYC_60 : CYC_50;
    always @(posedge REF_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            ctl_q <= 4'h1;
            off_q <= 4'hF;
            tc_q  <= 4'h0;
            dty_q <= 1'b0;
            cnt_q <= 20'h0;
        end else begin
            // A write during integration leaves its length open
            dty_q <= cfg_w | (dty_q & CONV_GATE_O);
            cnt_q <= CONV_GATE_O ? cnt_q + 20'h1 : 20'h0;
            if (cfg_w & (PADDR_I == 8'h00))
                ctl_q <= PWDATA_I[3:0];
            if (cfg_w & (PADDR_I != 8'h00)) begin
                off_q[idx_w] <= PWDATA_I[2:0] == 3'h0;
                tc_q[idx_w]  <= PWDATA_I[2];
            end
        end
    end
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_B_I);
    property p_rdy; PSEL_I && !PENABLE_I |=> PREADY_O ##1 !PREADY_O; endproperty
    a_rdy: assert property (p_rdy) else $error("ready not one cycle after setup");
    property p_err; PSEL_I && !PENABLE_I && PADDR_I >= 8'h40 |=> PSLVERR_O; endproperty
    a_err: assert property (p_err) else $error("unmapped access without error");
    property p_req; CONV_REQ_O |=> !CONV_REQ_O; endproperty
    a_req: assert property (p_req) else $error("sample request longer than a cycle");
    property p_irq; PROC_IRQ_O |-> ctl_q[1] ##1 !PROC_IRQ_O; endproperty
    a_irq: assert property (p_irq) else $error("limit event bad");
    property p_evt; $rose(DIAG_ENC_O) |-> DIAG_EVT_O; endproperty
    a_evt: assert property (p_evt) else $error("supply short without event");
    property p_pin; !ENC_SHORT_I [*6] |-> !DIAG_ENC_O; endproperty
    a_pin: assert property (p_pin) else $error("supply short without pin");
    property p_grp; !ctl_q[0] [*3] |-> !DIAG_ENC_O; endproperty
    a_grp: assert property (p_grp) else $error("supply short with diag off");
    property p_gate; $fell(CONV_GATE_O) && !dty_q |-> cnt_q == exp_w; endproperty
    a_gate: assert property (p_gate) else $error("integration length wrong");
    property p_off; $rose(CONV_GATE_O) && !dty_q |-> !off_q[CONV_CH_O]; endproperty
    a_off: assert property (p_off) else $error("disabled channel converted");
endmodule // aid_chk
bind aid_core aid_chk #(.CYC_50(CYC_50), .CYC_60(CYC_60), .CYC_FAST(CYC_FAST)) aid_chk_i (
    .REF_CLK_I(REF_CLK_I), .RST_B_I(RST_B_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PREADY_O(PREADY_O),
    .PSLVERR_O(PSLVERR_O), .CONV_GATE_O(CONV_GATE_O), .CONV_CH_O(CONV_CH_O),
    .CONV_REQ_O(CONV_REQ_O), .ENC_SHORT_I(ENC_SHORT_I), .PROC_IRQ_O(PROC_IRQ_O),
    .DIAG_EVT_O(DIAG_EVT_O), .DIAG_ENC_O(DIAG_ENC_O));
`default_nettype wire

// ===== aid_conv.sv
// Converter model: answers each sample request after a settable delay
`timescale 1ns/1ns
`default_nettype none
module aid_conv (
    // Clock, reset, request
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        req_i,
    input  wire logic [1:0]  ch_i,
    // Answer delay and per-channel answers
    input  wire logic [4:0]  dly_i,
    input  wire logic [63:0] val_i,
    input  wire logic [3:0]  open_i,
    input  wire logic [3:0]  short_i,
    input  wire logic [3:0]  oshort_i,
    // Sample to the core
    output logic             valid_o,
    output logic [18:0]      smp_o
);
    logic [1:0] ch_q;
    logic [5:0] cnt_q;
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            valid_o <= 1'b0;
            smp_o   <= 19'h0;
            ch_q    <= 2'h0;
            cnt_q   <= 6'h0;
        end else begin
            valid_o <= 1'b0;
            // Off the valid cycle the lines toggle, so stale data is never reused
            smp_o <= ~smp_o;
            if (req_i) begin
                ch_q  <= ch_i;
                cnt_q <= {1'b0, dly_i} + 6'h1;
            end else if (cnt_q == 6'h1) begin
                valid_o <= 1'b1;
                smp_o   <= {val_i[{ch_q, 4'h0} +: 16], open_i[ch_q], short_i[ch_q], oshort_i[ch_q]};
                cnt_q   <= 6'h0;
            end else if (cnt_q != 6'h0) begin
                cnt_q <= cnt_q - 6'h1;
            end
        end
    end
endmodule // aid_conv
`default_nettype wire

// ===== test_analog_input_diag_limit_smoothing.sv
// Self-checking bench for the analog input core
`timescale 1ns/1ns
`default_nettype none
`include "aid_map.vh"
module test_analog_input_diag_limit_smoothing;
    logic        clk = 1'b0, rst_b = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, enc = 1'b0;
    logic [7:0]  padr = 8'h00;
    logic [31:0] pwd = 32'h0, prd, rd_d;
    logic        rdy, err, gate, req, sv, irq, evt, enc_o, rd_e;
    logic [1:0]  ch;
    logic [18:0] smp;
    logic [15:0] temp = 16'h0;
    logic [63:0] tab = 64'h0;
    logic [3:0]  sht = 4'h0, osh = 4'h0, opn = 4'h0;
    logic [4:0]  dly = 5'h0;
    logic [31:0] cfg [4];
    integer      ev [4];
    integer      bad_count = 0, cmp_count = 0, irq_n = 0, evt_n = 0, seed = 32'h6821;
    integer      r2, r3, t, n0, i;
    always #50 clk = ~clk;
    aid_core #(.CYC_50(20'h10), .CYC_60(20'hC), .CYC_FAST(20'h6)) aid_core_i (
        .REF_CLK_I(clk), .RST_B_I(rst_b), .CE_I(1'b1), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(rdy),
        .PSLVERR_O(err), .CONV_GATE_O(gate), .CONV_CH_O(ch), .CONV_REQ_O(req),
        .SMP_VALID_I(sv), .SMP_DATA_I(smp[18:3]), .SMP_OPEN_I(smp[2]), .SMP_SHORT_I(smp[1]),
        .SMP_OSHORT_I(smp[0]), .TEMP_INT_I(temp), .ENC_SHORT_I(enc), .PROC_IRQ_O(irq),
        .DIAG_EVT_O(evt), .DIAG_ENC_O(enc_o));
    aid_conv aid_conv_i (.clk_i(clk), .rst_b_i(rst_b), .req_i(req), .ch_i(ch), .dly_i(dly),
        .val_i(tab), .open_i(opn), .short_i(sht), .oshort_i(osh), .valid_o(sv), .smp_o(smp));
    task automatic give_verdict;
        if (bad_count == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwr  <= w;
        padr <= a;
        pwd  <= d;
        @(posedge clk);
        pen <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge clk);
        end while (rdy !== 1'b1);
        rd_d = prd;
        rd_e = err;
        psel <= 1'b0;
        pen  <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd_d & m, exp & m);
    endtask
    task automatic setcfg;
        for (i = 0; i < 4; i++)
            apb(1'b1, 8'(`AID_CHCFG_OFS + 4 * i), cfg[i]);
    endtask
    task automatic rounds(input integer n);
        while (n > 0) begin
            @(posedge clk);
            if (sv === 1'b1)
                n = n - 1;
        end
        repeat (4) @(posedge clk);
    endtask
    // Reference model of the delivered value
    function automatic integer expv(input integer ty, wb, raw, refv);
        integer thr;
        thr = ty == 2 ? (`AID_U_WB_MV - `AID_U_LO_MV) * 27648 / (`AID_U_HI_MV - `AID_U_LO_MV)
                      : (`AID_I_WB_UA - `AID_I_LO_UA) * 27648 / (`AID_I_HI_UA - `AID_I_LO_UA);
        expv = ty >= 4 ? raw + refv : raw >= thr ? raw : wb ? 32'h7FFF : 32'h8000;
    endfunction
    always @(posedge clk) begin
        irq_n <= irq_n + (irq === 1'b1);
        evt_n <= evt_n + (evt === 1'b1);
    end
    initial begin
        repeat (30000) @(posedge clk);
        bad_count = bad_count + 1;
        give_verdict();
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rchk(`AID_CTRL_OFS, 32'hF, 32'h1);
        rchk(`AID_CHCFG_OFS, 32'h7FF, 32'h0);
        rchk(`AID_LIM_OFS, 32'hFFFFFFFF, 32'h7FFF8000);
        apb(1'b0, 8'h40, 32'h0);
        chk(rd_e, 32'h1);
        apb(1'b1, `AID_FIXREF_OFS, 32'h64);
        rchk(`AID_FIXREF_OFS, 32'hFFFF, 32'h0);
        r2 = $random(seed) % 1000;
        r3 = $random(seed) % 1000;
        t = $random(seed) % 500;
        temp <= t[15:0];
        tab <= {r3[15:0], r2[15:0], 16'hE890, 16'hE890};
        sht <= 4'h1;
        osh <= 4'h1;
        opn <= 4'h4;
        dly <= 5'({$random(seed)} % 8);
        cfg = '{32'h1A2, 32'h43, 32'h24, 32'h204};
        setcfg();
        rounds(8);
        ev = '{expv(2, 1, -6000, 0), expv(3, 0, -6000, 0), 32'h7FFF, expv(4, 1, r3, t)};
        for (i = 0; i < 4; i++)
            rchk(8'(`AID_VAL_OFS + 4 * i), 32'hFFFF, ev[i]);
        rchk(`AID_DIAG_OFS, 32'hFFFFFFFF, 32'h10419);
        enc <= 1'b1;
        apb(1'b1, `AID_CTRL_OFS, 32'hC);
        rounds(8);
        rchk(`AID_DIAG_OFS, 32'hFFFFFFFF, 32'h8);
        chk(enc_o, 32'h0);
        n0 = evt_n;
        apb(1'b1, `AID_CTRL_OFS, 32'h1);
        repeat (6) @(posedge clk);
        chk(enc_o, 32'h1);
        chk(evt_n > n0, 32'h1);
        rchk(`AID_DIAG_OFS, 32'h80000000, 32'h80000000);
        enc <= 1'b0;
        opn <= 4'h0;
        cfg[2] = 32'h424;
        setcfg();
        apb(1'b1, `AID_FIXREF_OFS, 32'h60F);
        rchk(`AID_FIXREF_OFS, 32'hFFFF, 32'h0);
        apb(1'b1, `AID_FIXREF_OFS, 32'hFFFFFA56);
        rchk(`AID_FIXREF_OFS, 32'hFFFF, 32'hFA56);
        rounds(8);
        rchk(8'(`AID_VAL_OFS + 8), 32'hFFFF, expv(4, 1, r2, -1450));
        cfg = '{32'h0, 32'h0, 32'h25, 32'h204};
        tab[63:48] <= 16'h0;
        opn <= 4'h4;
        temp <= 16'h0;
        setcfg();
        apb(1'b1, 8'(`AID_LIM_OFS + 12), 32'h0064FF9C);
        rounds(4);
        apb(1'b1, `AID_CTRL_OFS, 32'hB);
        apb(1'b1, `AID_LIMEVT_OFS, 32'hFF);
        n0 = irq_n;
        tab[63:48] <= 16'h01F4;
        rounds(4);
        chk(irq_n - n0, 32'h1);
        rchk(`AID_LIMEVT_OFS, 32'hFF, 32'h8);
        apb(1'b1, `AID_LIMEVT_OFS, 32'h8);
        rchk(`AID_LIMEVT_OFS, 32'hFF, 32'h0);
        tab[63:48] <= 16'hFE0C;
        rounds(4);
        chk(irq_n - n0, 32'h2);
        rchk(`AID_LIMEVT_OFS, 32'hFF, 32'h80);
        rchk(8'(`AID_VAL_OFS + 8), 32'hFFFF, r2);
        // Only channel 3 left on, so every sample counted is its own
        cfg = '{32'h0, 32'h0, 32'h0, 32'h20C};
        setcfg();
        rounds(1);
        tab[63:48] <= 16'h01F4;
        rounds(4);
        t = -500;
        repeat (4) t = t + ((500 - t) >>> 2);
        rchk(8'(`AID_VAL_OFS + 12), 32'hFFFF, t);
        give_verdict();
    end
endmodule // test_analog_input_diag_limit_smoothing
`default_nettype wire
